//--- dwssp_pkg.sv
// constants and types shared by the dual wiper serial shift port
`default_nettype none

package dwssp_pkg;

   // --------------------------------------------------------------
   // shift register layout
   // --------------------------------------------------------------
   localparam int          SHIFT_W      = 17;     // whole serial word
   localparam int          WIPER_W      = 8;      // one wiper setting
   localparam int          STACK_POS    = 16;     // sits at the cascade end, leaves first
   localparam int          POT1_MSB     = 15;     // potentiometer one, msb first on the wire
   localparam int          POT1_LSB     = 8;
   localparam int          POT0_MSB     = 7;      // potentiometer zero, sent last
   localparam int          POT0_LSB     = 0;

   // --------------------------------------------------------------
   // power-up values
   // --------------------------------------------------------------
   localparam logic [7:0]  WIPER_RESET  = 8'h80;  // mid-scale, msb only
   localparam logic        STACK_RESET  = 1'h0;   // stacked output follows wiper zero
   localparam logic [16:0] SHIFT_RESET  = {STACK_RESET, WIPER_RESET, WIPER_RESET};

   // --------------------------------------------------------------
   // bit counter for word alignment status
   // --------------------------------------------------------------
   localparam int          BIT_CNT_W    = 5;
   localparam logic [4:0]  BIT_CNT_ZERO = 5'h00;
   localparam logic [4:0]  BIT_CNT_LAST = 5'h10;  // seventeenth bit of a word
   localparam logic [4:0]  BIT_CNT_ONE  = 5'h01;

   // --------------------------------------------------------------
   // pin sampling
   // --------------------------------------------------------------
   localparam int          SYNC_STAGES  = 3;      // flops on each pin input
   localparam int          NUM_PINS     = 3;
   localparam int          PIN_SEL      = 0;      // port_select
   localparam int          PIN_SCLK     = 1;      // serial clock
   localparam int          PIN_SDI      = 2;      // serial data in

   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 8;   // ref_clk at 125 MHz
   localparam int          CHAIN_DELAY_NS  = 50;  // longest clock edge to cascade bit
   // longest time: rounds down, at least one cycle
   localparam int          CHAIN_DELAY_CYC = (CHAIN_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                             (CHAIN_DELAY_NS / CLK_PERIOD_NS);

   // --------------------------------------------------------------
   // port state
   // --------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE,                                    // deselected, register frozen
      ST_SHIFT                                    // selected, shifting on clock rises
   } dwssp_state_e;

endpackage

`default_nettype wire

//--- dwssp_pin_sync.sv
// three-flop pin synchroniser with agreement filter and edge pulses
`default_nettype none

module dwssp_pin_sync (
   // clocking
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic ce,
   // pin from outside the clock domain
   input  wire logic pin_async,
   // filtered level and its edges
   output logic      level_q,
   output logic      rise_q,
   output logic      fall_q
);

   // --------------------------------------------------------------
   // storage
   // --------------------------------------------------------------
   logic [dwssp_pkg::SYNC_STAGES-1:0] stage_q;   // stage 0 is read only by stage 1
   logic [dwssp_pkg::SYNC_STAGES-1:0] stage_d;
   logic                              level_d;
   logic                              rise_d;
   logic                              fall_d;
   logic                              agree;     // last two stages match

   // next values: a change counts once stages two and three agree,
   // which rejects a single-cycle glitch on the pin
   always_comb begin
      stage_d = {stage_q[dwssp_pkg::SYNC_STAGES-2:0], pin_async};
      agree   = (stage_q[1] == stage_q[2]);
      level_d = agree ? stage_q[2] : level_q;
      rise_d  = agree & stage_q[2] & ~level_q;
      fall_d  = agree & ~stage_q[2] & level_q;
   end

   // registers; clock enable low freezes everything
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stage_q <= '0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
         fall_q  <= 1'b0;
      end else if (ce) begin
         stage_q <= stage_d;
         level_q <= level_d;
         rise_q  <= rise_d;
         fall_q  <= fall_d;
      end
   end

endmodule

`default_nettype wire

//--- dwssp_serial_port.sv
// dual wiper serial shift port: select, serial clock and data into a 17-bit word
`default_nettype none

// Summary of operation
// - port ignores clock and data when deselected
// - sample data on each serial clock rise
// - seventeen-bit register: two wipers plus stack
// - position zero holds the stack select
// - positions one to eight: wiper one
// - positions nine to sixteen: wiper zero
// - select fall copies register into wipers
// - power-up puts both wipers at mid-scale
// - stack bit picks stacked output wiper
// - cascade bit appears within fifty nanoseconds
// - stack select bit leaves first
// - cascade output always driven
// - looped chain restores register after seventeen clocks

module dwssp_serial_port (
   // clocking
   input  wire logic       ref_clk,
   input  wire logic       srst,
   input  wire logic       ce,
   // three-wire serial pins
   input  wire logic       port_select,
   input  wire logic       serial_clk,
   input  wire logic       serial_data_in,
   // cascade pin
   output logic            chain_data_out,
   // applied wiper settings
   output logic [7:0]      wiper_zero_terminal,
   output logic [7:0]      wiper_one_terminal,
   output logic [7:0]      stacked_wiper_out,
   output logic            stack_select_q,
   // status
   output logic            port_active_q,
   output logic            word_aligned_q
);

   // --------------------------------------------------------------
   // pin sampling
   // --------------------------------------------------------------
   logic [dwssp_pkg::NUM_PINS-1:0] pin_raw;      // pins gathered for the loop
   logic [dwssp_pkg::NUM_PINS-1:0] pin_level;    // filtered levels
   logic [dwssp_pkg::NUM_PINS-1:0] pin_rise;     // one-cycle rise pulses
   logic [dwssp_pkg::NUM_PINS-1:0] pin_fall;     // one-cycle fall pulses

   assign pin_raw[dwssp_pkg::PIN_SEL]  = port_select;
   assign pin_raw[dwssp_pkg::PIN_SCLK] = serial_clk;
   assign pin_raw[dwssp_pkg::PIN_SDI]  = serial_data_in;

   // one synchroniser per pin; data shares the clock's latency so the
   // controller's setup before its clock edge carries over unchanged
   for (genvar gi = 0; gi < dwssp_pkg::NUM_PINS; gi++) begin : g_sync
      dwssp_pin_sync u_sync (
         .ref_clk   (ref_clk),
         .srst      (srst),
         .ce        (ce),
         .pin_async (pin_raw[gi]),
         .level_q   (pin_level[gi]),
         .rise_q    (pin_rise[gi]),
         .fall_q    (pin_fall[gi])
      );
   end

   // --------------------------------------------------------------
   // decoded pin events
   // --------------------------------------------------------------
   logic sel_rise;                               // select went high
   logic sel_fall;                               // select went low
   logic sclk_rise;                              // serial clock rose
   logic sdi_level;                              // data as seen at that rise

   assign sel_rise  = pin_rise[dwssp_pkg::PIN_SEL];
   assign sel_fall  = pin_fall[dwssp_pkg::PIN_SEL];
   assign sclk_rise = pin_rise[dwssp_pkg::PIN_SCLK];
   assign sdi_level = pin_level[dwssp_pkg::PIN_SDI];

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   dwssp_pkg::dwssp_state_e state_q;             // idle or shifting
   dwssp_pkg::dwssp_state_e state_d;
   logic [16:0]             shift_q;             // the serial word
   logic [16:0]             shift_d;
   logic [7:0]              wiper0_q;            // applied wiper zero
   logic [7:0]              wiper0_d;
   logic [7:0]              wiper1_q;            // applied wiper one
   logic [7:0]              wiper1_d;
   logic                    stack_q;             // applied stack select
   logic                    stack_d;
   logic [7:0]              stacked_q;           // mux result, registered
   logic [7:0]              stacked_d;
   logic [4:0]              bit_cnt_q;           // bits shifted modulo seventeen
   logic [4:0]              bit_cnt_d;
   logic                    aligned_d;
   logic                    active_d;
   logic                    do_shift;            // shift in this cycle

   // --------------------------------------------------------------
   // port control
   // --------------------------------------------------------------

   // the port only follows the clock while select is high; a select
   // fall while idle cannot occur, so loads come only from ST_SHIFT
   always_comb begin
      state_d  = state_q;
      do_shift = 1'b0;
      unique case (state_q)
         dwssp_pkg::ST_IDLE: begin
            if (sel_rise) begin
               state_d = dwssp_pkg::ST_SHIFT;
            end
         end
         dwssp_pkg::ST_SHIFT: begin
            if (sel_fall) begin
               state_d = dwssp_pkg::ST_IDLE;
            end else begin
               do_shift = sclk_rise;
            end
         end
      endcase
   end

   // --------------------------------------------------------------
   // shift register and applied settings
   // --------------------------------------------------------------

   // new data enters at position zero of the vector and walks toward
   // the cascade end; the first bit sent ends up at the top after a
   // full word, so bit 16 of the vector carries the stack select
   always_comb begin
      shift_d   = shift_q;
      wiper0_d  = wiper0_q;
      wiper1_d  = wiper1_q;
      stack_d   = stack_q;
      bit_cnt_d = bit_cnt_q;
      if (do_shift) begin
         shift_d = {shift_q[dwssp_pkg::SHIFT_W-2:0], sdi_level};
         // count bits so software can see whether a whole word went in
         if (bit_cnt_q == dwssp_pkg::BIT_CNT_LAST) begin
            bit_cnt_d = dwssp_pkg::BIT_CNT_ZERO;
         end else begin
            bit_cnt_d = bit_cnt_q + dwssp_pkg::BIT_CNT_ONE;
         end
      end
      if (state_q == dwssp_pkg::ST_IDLE) begin
         shift_d = shift_q;
      end
      if ((state_q == dwssp_pkg::ST_SHIFT) && sel_fall) begin
         stack_d   = shift_q[dwssp_pkg::STACK_POS];
         wiper1_d  = shift_q[dwssp_pkg::POT1_MSB:dwssp_pkg::POT1_LSB];
         wiper0_d  = shift_q[dwssp_pkg::POT0_MSB:dwssp_pkg::POT0_LSB];
         // a new transaction counts its own bits from zero
         bit_cnt_d = dwssp_pkg::BIT_CNT_ZERO;
      end
      stacked_d = stack_d ? wiper1_d : wiper0_d;
      aligned_d = (bit_cnt_d == dwssp_pkg::BIT_CNT_ZERO);
      active_d  = (state_d == dwssp_pkg::ST_SHIFT);
   end

   // registers; srst stands for power-up, there is no other reset
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q        <= dwssp_pkg::ST_IDLE;
         shift_q        <= dwssp_pkg::SHIFT_RESET;
         wiper0_q       <= dwssp_pkg::WIPER_RESET;
         wiper1_q       <= dwssp_pkg::WIPER_RESET;
         stack_q        <= dwssp_pkg::STACK_RESET;
         stacked_q      <= dwssp_pkg::WIPER_RESET;
         bit_cnt_q      <= dwssp_pkg::BIT_CNT_ZERO;
         word_aligned_q <= 1'b1;
         port_active_q  <= 1'b0;
      end else if (ce) begin
         state_q        <= state_d;
         shift_q        <= shift_d;
         wiper0_q       <= wiper0_d;
         wiper1_q       <= wiper1_d;
         stack_q        <= stack_d;
         stacked_q      <= stacked_d;
         bit_cnt_q      <= bit_cnt_d;
         word_aligned_q <= aligned_d;
         port_active_q  <= active_d;
      end
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------

   // the cascade bit is the top flop of the word itself: it shows the
   // stack select before the first clock and is never tristated, so a
   // looped chain rotates the word back into place after a full count.
   // pin to cascade takes five ref_clk cycles, inside CHAIN_DELAY_CYC.
   // cascade bit timing
   assign chain_data_out      = shift_q[dwssp_pkg::STACK_POS];
   assign wiper_zero_terminal = wiper0_q;
   assign wiper_one_terminal  = wiper1_q;
   assign stacked_wiper_out   = stacked_q;
   assign stack_select_q      = stack_q;

endmodule

`default_nettype wire

//--- dwssp_serial_port_props.sv
// concurrent checks on the ports of the dual wiper serial shift port
`default_nettype none

module dwssp_serial_port_props (
   // clocking
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       ce,
   // serial pins
   input wire logic       port_select,
   input wire logic       serial_clk,
   input wire logic       serial_data_in,
   input wire logic       chain_data_out,
   // applied settings and status
   input wire logic [7:0] wiper_zero_terminal,
   input wire logic [7:0] wiper_one_terminal,
   input wire logic [7:0] stacked_wiper_out,
   input wire logic       stack_select_q,
   input wire logic       port_active_q,
   input wire logic       word_aligned_q
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // assertions, one clock domain, reset masks them all
   // ---------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_stack_mux_pick: assert property (
      stacked_wiper_out == (stack_select_q ? wiper_one_terminal : wiper_zero_terminal))
      else $error("stacked output does not follow stack select");
   a_reset_mid_scale: assert property ($fell(srst) |->
      wiper_zero_terminal == dwssp_pkg::WIPER_RESET && wiper_one_terminal == dwssp_pkg::WIPER_RESET)
      else $error("wipers not at mid-scale after reset");
   a_wipers_held_busy: assert property (port_active_q |->
      $stable(wiper_zero_terminal) && $stable(wiper_one_terminal) && $stable(stack_select_q))
      else $error("wiper setting moved while selected");
   a_chain_idle_frozen: assert property (
      !port_active_q && !$past(port_active_q) |-> $stable(chain_data_out))
      else $error("cascade bit moved while deselected");
   // a cascade change must trail a serial clock rise by the fixed pipeline depth
   a_chain_after_rise: assert property ($changed(chain_data_out) |->
      $past(serial_clk, 4))
      else $error("cascade bit changed outside its latency window");
   a_select_wakes_port: assert property ($rose(port_select) |-> ##[3:6] port_active_q)
      else $error("port not active after select rise");
   a_active_needs_sel: assert property ($rose(port_active_q) |->
      $past(port_select, 3) && $past(port_select, 1))
      else $error("port active without select");
   a_deselect_apply: assert property ($fell(port_select) |-> ##[3:6] !port_active_q)
      else $error("port still active after select fall");
   // main scenarios reached
   c_apply_seen: cover property ($fell(port_active_q));
   c_chain_shift: cover property (port_active_q && $changed(chain_data_out));
   c_stack_one: cover property ($rose(stack_select_q));
endmodule

bind dwssp_serial_port dwssp_serial_port_props dwssp_serial_port_props_inst (
   .ref_clk(ref_clk), .srst(srst), .ce(ce), .port_select(port_select),
   .serial_clk(serial_clk), .serial_data_in(serial_data_in),
   .chain_data_out(chain_data_out), .wiper_zero_terminal(wiper_zero_terminal),
   .wiper_one_terminal(wiper_one_terminal), .stacked_wiper_out(stacked_wiper_out),
   .stack_select_q(stack_select_q), .port_active_q(port_active_q),
   .word_aligned_q(word_aligned_q));

`default_nettype wire

//--- dwssp_ctrl_model.sv
// behavioural controlling processor on the three-wire serial pins
`default_nettype none

module dwssp_ctrl_model (
   // clocking and cascade return
   input  wire logic ref_clk,
   input  wire logic chain_data_out,
   // three-wire pins
   output var logic  port_select,
   output var logic  serial_clk,
   output var logic  serial_data_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // pin driving, link clock 64 ns: 3 cycles high, 5 low
   // ---------------------------------------------------------------
   initial begin
      port_select    = 1'b0;
      serial_clk     = 1'b0;
      serial_data_in = 1'b0;
   end
   // wait n edges, then move off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // one frame; lp loops the cascade bit back, sel low clocks a deselected port
   task automatic frame(input logic [16:0] w, input logic lp, input int n,
                        input logic sel, output logic [16:0] seen);
      seen = 17'h00000;
      port_select = sel;
      cyc(8);
      for (int i = 0; i < n; i++) begin
         // collect cascade bits, stack bit leaves first
         seen = {seen[15:0], chain_data_out};
         // stack first, then wipers msb first, n bits of the 17-bit word
         serial_data_in = lp ? chain_data_out : w[16 - i];
         cyc(2);
         serial_clk = 1'b1;
         cyc(3);
         serial_clk = 1'b0;
         cyc(3);
      end
      // drop select; released data line shows the inverse so stale bits fail
      port_select    = 1'b0;
      serial_data_in = ~serial_data_in;
      cyc(8);
   endtask
endmodule

`default_nettype wire

//--- dwssp_serial_port_test.sv
// self-checking bench for the dual wiper serial shift port
`default_nettype none

module dwssp_serial_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // clock, reset, wiring
   // ---------------------------------------------------------------
   localparam logic [16:0] W_A = 17'h1a53c;  // stack 1, wiper one a5, wiper zero 3c
   localparam logic [16:0] W_B = 17'h0c35a;  // stack 0, wiper one c3, wiper zero 5a
   logic        ref_clk = 1'b0;
   logic        srst    = 1'b1;
   logic        ce      = 1'b1;             // held on: freezing is not exercised
   wire  logic  port_select, serial_clk, serial_data_in, chain_data_out;
   wire  logic  stack_select_q, port_active_q, word_aligned_q;
   wire  logic [7:0] wiper_zero_terminal, wiper_one_terminal, stacked_wiper_out;
   logic [16:0] seen;
   int          error_cnt = 0;
   int          compares  = 0;
   logic        aligned_end = 1'b0;         // word alignment in the last selected cycle
   always #4 ref_clk = ~ref_clk;
   // keep the alignment status of the last selected cycle, since it is
   // forced back to aligned at the very edge that applies the word
   always @(posedge ref_clk) begin
      if (port_active_q) begin
         aligned_end <= word_aligned_q;
      end
   end
   dwssp_serial_port dwssp_serial_port_inst (
      .ref_clk(ref_clk), .srst(srst), .ce(ce), .port_select(port_select),
      .serial_clk(serial_clk), .serial_data_in(serial_data_in),
      .chain_data_out(chain_data_out), .wiper_zero_terminal(wiper_zero_terminal),
      .wiper_one_terminal(wiper_one_terminal), .stacked_wiper_out(stacked_wiper_out),
      .stack_select_q(stack_select_q), .port_active_q(port_active_q),
      .word_aligned_q(word_aligned_q));
   dwssp_ctrl_model dwssp_ctrl_model_inst (
      .ref_clk(ref_clk), .chain_data_out(chain_data_out), .port_select(port_select),
      .serial_clk(serial_clk), .serial_data_in(serial_data_in));
   // ---------------------------------------------------------------
   // compares and verdict
   // ---------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk17(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // applied outputs against a word laid out stack, wiper one, wiper zero
   task automatic chk_applied(input logic [16:0] w);
      chk8(wiper_zero_terminal, w[7:0]);
      chk8(wiper_one_terminal, w[15:8]);
      chk8({7'h00, stack_select_q}, {7'h00, w[16]});
      chk8(stacked_wiper_out, w[16] ? w[15:8] : w[7:0]);
      chk8({7'h00, chain_data_out}, {7'h00, w[16]});
   endtask
   task automatic conclude;
      if (error_cnt == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      chk_applied(dwssp_pkg::SHIFT_RESET);
   endtask
   // write a word; the bits shifted out must be the previous word
   task automatic t_write(input logic [16:0] w, input logic [16:0] prev);
      dwssp_ctrl_model_inst.frame(w, 1'b0, 17, 1'b1, seen);
      chk17(seen, prev);
      chk8({7'h00, aligned_end}, 8'h01);
      chk_applied(w);
   endtask
   // a short transfer applies whatever has been shifted so far
   task automatic t_short(input logic [16:0] w, input logic [16:0] prev);
      dwssp_ctrl_model_inst.frame(w, 1'b0, 16, 1'b1, seen);
      chk17(seen, {1'b0, prev[16:1]});
      chk8({7'h00, aligned_end}, 8'h00);
      chk_applied({prev[0], w[16:1]});
   endtask
   // clocks while deselected, then a select pulse with no clocks
   task automatic t_idle(input logic [16:0] cur);
      dwssp_ctrl_model_inst.frame(~cur, 1'b0, 17, 1'b0, seen);
      dwssp_ctrl_model_inst.frame(~cur, 1'b0, 0, 1'b1, seen);
      chk_applied(cur);
   endtask
   // cascade looped back: read out and restore unchanged
   task automatic t_loop(input logic [16:0] cur);
      dwssp_ctrl_model_inst.frame(17'h00000, 1'b1, 17, 1'b1, seen);
      chk17(seen, cur);
      chk8({7'h00, aligned_end}, 8'h01);
      chk_applied(cur);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 srst = 1'b0;
      repeat (2) @(posedge ref_clk);
      t_reset();
      t_write(W_A, dwssp_pkg::SHIFT_RESET);
      t_write(W_B, W_A);
      t_idle(W_B);
      t_loop(W_B);
      t_write(W_A, W_B);
      t_short(W_B, W_A);
      conclude();
   end
   // watchdog, well beyond the roughly nine hundred cycles the frames take
   initial begin
      #50us;
      error_cnt++;
      conclude();
   end
endmodule

`default_nettype wire
